/* cbd_defines.svh */
// Purpose: shared constants for the branch, bit and control decoder
// Assumes: included by its bare name wherever the constants are used
// Notes: widths are in bits, timing counts in core clock cycles
`ifndef CBD_DEFINES_SVH
`define CBD_DEFINES_SVH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PC_W 12
`define RESET_PC 12'h000
`define STACK_DEPTH 3'h6

// ----------------------------------------
// opcode low three bits, bit 3 is the direction or variant bit
// ----------------------------------------
`define KIND_BNZ 3'h0
`define KIND_CALL 3'h1
`define KIND_BNC 3'h2
`define KIND_BIT 3'h3
`define KIND_BZ 3'h4
`define KIND_CTRL 3'h5
`define KIND_BC 3'h6

// ----------------------------------------
// inherent control opcodes
// ----------------------------------------
`define OP_NOP 8'h2d
`define OP_RET 8'hcd
`define OP_INTERRUPT_RETURN 8'h4d
`define OP_STOP 8'h6d
`define OP_WAIT 8'hed

// ----------------------------------------
// cycles per instruction
// ----------------------------------------
`define CYC_SHORT 3'h2
`define CYC_BIT_TEST 3'h5
`define CYC_BIT_SETCLR 3'h4
`define CYC_ABS 3'h4
`define CYC_CTRL 3'h2

`endif

/* cbd_pkg.sv */
// Purpose: types shared by the decoder and its bench
// Assumes: nothing beyond the defines header
// Notes: packed structs carry grouped signals across ports
package cbd_pkg;

  typedef enum logic [3:0] {
    CL_BNZ, CL_BNC, CL_BZ, CL_BC, CL_BTST, CL_BSC, CL_CALL, CL_JUMP,
    CL_NOP, CL_RET, CL_INTERRUPT_RETURN, CL_STOP, CL_WAIT, CL_FOREIGN
  } instr_class_e;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_FOREIGN} core_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } data_req_s;

  typedef struct packed {
    logic z;
    logic c;
  } flags_s;

endpackage

/* ret_stack.sv */
// Purpose: circular return-address stack with registered top output
// Assumes: at most one push and one pop per cycle
// Notes: overflow silently overwrites the oldest entry
`include "cbd_defines.svh"

module ret_stack (
  input wire logic clk_sys_in, // core clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic push_in, // store push_data_in on top
  input wire logic pop_in, // drop the top entry
  input wire logic [11:0] push_data_in, // address to store
  output logic [11:0] top_out // top entry, one cycle behind
);

  logic [11:0] mem [0:`STACK_DEPTH-1];
  logic [2:0] sp;

  wire logic [2:0] top_idx = (sp == 3'h0) ? (`STACK_DEPTH - 3'h1) : (sp - 3'h1);
  // push and pop together replace the top in place
  wire logic [2:0] wr_idx = pop_in ? top_idx : sp;
  wire logic [2:0] sp_inc = (sp == `STACK_DEPTH - 3'h1) ? 3'h0 : (sp + 3'h1);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sp <= 3'h0;
    end else if (push_in && !pop_in) begin
      sp <= sp_inc;
    end else if (pop_in && !push_in) begin
      sp <= top_idx;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push_in) begin
      mem[wr_idx] <= push_data_in;
    end
    top_out <= mem[top_idx];
  end

endmodule

/* cpu_branch_control_decode.sv */
// Purpose: decode and execute branch, bit, control, jump and call instructions
// Assumes: program and data memories answer combinationally in the same cycle
// Notes: other opcodes are handed out and finished by the rest of the core
//
// Functional notes
// - branch only when the selected condition holds, else fall through.
// - short branches are one byte, two cycles, flags untouched.
// - short branch reach is -15 to +16 around the branch address.
// - bit test branch displacement reaches -126 to +129.
// - bit test branch: three bytes, five cycles, bit into carry, zero kept.
// - any bit of any data byte can be tested.
// - bit set and clear change only the chosen bit.
// - bit set and clear: two bytes, four cycles, flags untouched.
// - bit number is a three-bit opcode field.
// - control instructions are one byte, two cycles; only interrupt return touches flags.
// - with watchdog selected, stop behaves as wait.
// - jump and call carry a twelve-bit absolute target.
// - jump and call: two bytes, four cycles, flags untouched.
// - low nibble map: 0 not-zero, 1 call, 2 no-carry, 3 bit test, 4 zero, 6 carry.
// - control group handles idle, returns and low-power entry.
// - short offset is a direction bit plus four-bit magnitude.
`include "cbd_defines.svh"

module cpu_branch_control_decode
  import cbd_pkg::*;
(
  input wire logic clk_sys_in, // core clock, 100 MHz
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic [7:0] prog_data_in, // byte at prog_addr_out
  output logic [11:0] prog_addr_out, // program fetch address
  input wire logic [7:0] data_rdata_in, // byte at data_req_out.addr
  output data_req_s data_req_out, // data-space address, write data, strobe
  input wire logic alu_flag_we_in, // other units update flags
  input wire flags_s alu_flags_in, // their new flags
  output flags_s flags_out, // zero and carry flags
  input wire logic watchdog_sel_in, // watchdog function selected
  input wire logic int_req_in, // interrupt request level
  input wire logic [11:0] int_vec_in, // interrupt vector address
  output logic int_ack_out, // pulse: interrupt taken
  output logic [7:0] opcode_out, // current opcode
  output logic foreign_op_out, // pulse: opcode for another unit
  input wire logic foreign_done_in, // other unit finished
  input wire logic [1:0] foreign_len_in, // its length in bytes, 1 to 3
  output logic wait_mode_out, // core idles in wait
  output logic stop_mode_out // core idles in stop
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic instr_class_e decode(input logic [7:0] op);
    instr_class_e r;
    r = CL_FOREIGN;
    case (op[2:0])
      `KIND_BNZ: r = CL_BNZ;
      `KIND_BNC: r = CL_BNC;
      `KIND_BZ: r = CL_BZ;
      `KIND_BC: r = CL_BC;
      `KIND_CALL: r = op[3] ? CL_JUMP : CL_CALL;
      `KIND_BIT: r = op[3] ? CL_BSC : CL_BTST;
      `KIND_CTRL: begin
        case (op)
          `OP_NOP: r = CL_NOP;
          `OP_RET: r = CL_RET;
          `OP_INTERRUPT_RETURN: r = CL_INTERRUPT_RETURN;
          `OP_STOP: r = CL_STOP;
          `OP_WAIT: r = CL_WAIT;
          default: r = CL_FOREIGN;
        endcase
      end
      default: r = CL_FOREIGN;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] last_idx(input instr_class_e c);
    logic [2:0] r;
    case (c)
      CL_BTST: r = `CYC_BIT_TEST - 3'h1;
      CL_BSC: r = `CYC_BIT_SETCLR - 3'h1;
      CL_CALL, CL_JUMP: r = `CYC_ABS - 3'h1;
      CL_NOP, CL_RET, CL_INTERRUPT_RETURN, CL_STOP, CL_WAIT: r = `CYC_CTRL - 3'h1;
      CL_FOREIGN: r = 3'h7;
      default: r = `CYC_SHORT - 3'h1;
    endcase
    return r;
  endfunction

  function automatic logic is_short(input instr_class_e c);
    return c == CL_BNZ || c == CL_BNC || c == CL_BZ || c == CL_BC;
  endfunction

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  core_state_e state, next_state;
  flags_s int_flags, next_flags;
  data_req_s next_req;
  logic [11:0] pc, next_pc, stack_top;
  logic [7:0] byte2, ee;
  logic [2:0] cyc;
  logic btst_take;

  wire instr_class_e cls = decode(opcode_out);
  wire logic run = state == ST_RUN;
  wire logic last = run && cyc != 3'h0 && cyc == last_idx(cls);
  wire logic [2:0] bitn = {opcode_out[5], opcode_out[6], opcode_out[7]};
  wire logic [7:0] mask = 8'h01 << bitn;
  wire logic tested = data_rdata_in[bitn];
  wire logic [7:0] modified = opcode_out[4] ? (data_rdata_in | mask) : (data_rdata_in & ~mask);
  wire logic wr_now = run && cyc == 3'h2 && cls == CL_BSC;
  wire logic foreign_end = state == ST_FOREIGN && foreign_done_in;
  wire logic [11:0] foreign_pc = pc + {10'h000, foreign_len_in};

  // ----------------------------------------
  // branch conditions and targets
  // ----------------------------------------
  wire logic br_taken = (cls == CL_BNZ && !flags_out.z) || (cls == CL_BZ && flags_out.z) ||
                        (cls == CL_BNC && !flags_out.c) || (cls == CL_BC && flags_out.c);
  // bit 3 set means backward; reach is -15 .. +16
  wire logic [11:0] short_tgt = opcode_out[3] ? (pc - {8'h00, opcode_out[7:4]}) :
                                (pc + {8'h00, opcode_out[7:4]} + 12'h001);
  wire logic [11:0] btst_tgt = pc + 12'h002 + {{4{ee[7]}}, ee};
  wire logic [11:0] abs_tgt = {opcode_out[7:4], byte2};

  assign next_pc = is_short(cls) ? (br_taken ? short_tgt : pc + 12'h001) :
                   (cls == CL_BTST) ? (btst_take ? btst_tgt : pc + 12'h003) :
                   (cls == CL_BSC) ? pc + 12'h002 :
                   (cls == CL_CALL || cls == CL_JUMP) ? abs_tgt :
                   (cls == CL_RET || cls == CL_INTERRUPT_RETURN) ? stack_top : pc + 12'h001;

  // ----------------------------------------
  // return stack and interrupt entry
  // ----------------------------------------
  // interrupts enter only at instruction boundaries or from idle
  wire logic int_take = int_req_in && (last || state == ST_WAIT || state == ST_STOP);
  wire logic push = (run && cyc == 3'h1 && cls == CL_CALL) || int_take;
  wire logic pop = last && (cls == CL_RET || cls == CL_INTERRUPT_RETURN);
  wire logic [11:0] push_data = int_take ? (last ? next_pc : pc) : pc + 12'h002;

  ret_stack u_stack (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .push_in(push),
    .pop_in(pop),
    .push_data_in(push_data),
    .top_out(stack_top)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (int_take) begin
          next_state = ST_RUN;
        end else if (cyc == 3'h1 && cls == CL_FOREIGN) begin
          next_state = ST_FOREIGN;
        end else if (last && cls == CL_STOP) begin
          next_state = watchdog_sel_in ? ST_WAIT : ST_STOP;
        end else if (last && cls == CL_WAIT) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT, ST_STOP: next_state = int_take ? ST_RUN : state;
      ST_FOREIGN: next_state = foreign_done_in ? ST_RUN : ST_FOREIGN;
      default: next_state = ST_RUN;
    endcase
  end

  // interrupt_return restore wins over carry copy and other units
  assign next_flags = (last && cls == CL_INTERRUPT_RETURN) ? int_flags :
                      (run && cyc == 3'h2 && cls == CL_BTST) ? {flags_out.z, tested} :
                      alu_flag_we_in ? alu_flags_in : flags_out;

  wire logic [11:0] next_addr = int_take ? int_vec_in :
                                foreign_end ? foreign_pc :
                                last ? next_pc :
                                (run && cyc == 3'h0) ? pc + 12'h001 :
                                (run && cyc == 3'h1) ? pc + 12'h002 : prog_addr_out;

  wire logic addr_load = run && cyc == 3'h1 && (cls == CL_BSC || cls == CL_BTST);
  assign next_req = '{addr: addr_load ? prog_data_in : data_req_out.addr,
                      wdata: wr_now ? modified : data_req_out.wdata,
                      we: wr_now};

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= ST_RUN;
      cyc <= 3'h0;
      pc <= `RESET_PC;
      prog_addr_out <= `RESET_PC;
    end else begin
      state <= next_state;
      cyc <= (run && !last && next_state == ST_RUN) ? cyc + 3'h1 : 3'h0;
      pc <= int_take ? int_vec_in : foreign_end ? foreign_pc : last ? next_pc : pc;
      prog_addr_out <= next_addr;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      opcode_out <= 8'h00;
      byte2 <= 8'h00;
      ee <= 8'h00;
      btst_take <= 1'b0;
    end else begin
      if (run && cyc == 3'h0) begin
        opcode_out <= prog_data_in;
      end
      if (run && cyc == 3'h1) begin
        byte2 <= prog_data_in;
      end
      if (run && cyc == 3'h2 && cls == CL_BTST) begin
        ee <= prog_data_in;
        btst_take <= tested == opcode_out[4];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      flags_out <= '0;
      int_flags <= '0;
      data_req_out <= '0;
      int_ack_out <= 1'b0;
      foreign_op_out <= 1'b0;
      wait_mode_out <= 1'b0;
      stop_mode_out <= 1'b0;
    end else begin
      flags_out <= next_flags;
      int_flags <= int_take ? flags_out : int_flags;
      data_req_out <= next_req;
      int_ack_out <= int_take;
      foreign_op_out <= run && cyc == 3'h1 && cls == CL_FOREIGN;
      wait_mode_out <= next_state == ST_WAIT;
      stop_mode_out <= next_state == ST_STOP;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  property p_short_len;
    run && cyc == 3'h0 && is_short(decode(prog_data_in)) |=> last && cyc == 3'h1;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short branch not two cycles");

  property p_short_target;
    last && is_short(cls) && !int_take |=>
      prog_addr_out == ($past(br_taken) ? $past(short_tgt) : $past(pc) + 12'h001) &&
      flags_out == ($past(alu_flag_we_in) ? $past(alu_flags_in) : $past(flags_out));
  endproperty
  a_short_target: assert property (p_short_target) else $error("short branch target wrong");

  property p_btst_len;
    run && cyc == 3'h0 && decode(prog_data_in) == CL_BTST |-> !last [*4] ##1 last;
  endproperty
  a_btst_len: assert property (p_btst_len) else $error("bit test branch not five cycles");

  property p_btst_carry;
    run && cyc == 3'h2 && cls == CL_BTST |=> flags_out.c == $past(tested) && flags_out.z == $past(flags_out.z);
  endproperty
  a_btst_carry: assert property (p_btst_carry) else $error("tested bit not in carry");

  property p_bsc_write;
    run && cyc == 3'h2 && cls == CL_BSC |=> data_req_out.we && last &&
      data_req_out.wdata[$past(bitn)] == $past(opcode_out[4]) &&
      ((data_req_out.wdata ^ $past(data_rdata_in)) & ~$past(mask)) == 8'h00;
  endproperty
  a_bsc_write: assert property (p_bsc_write) else $error("bit op touched other bits");

  property p_abs_target;
    last && (cls == CL_CALL || cls == CL_JUMP) && !int_take |=> prog_addr_out == $past(abs_tgt) && $past(cyc) == 3'h3;
  endproperty
  a_abs_target: assert property (p_abs_target) else $error("jump or call target wrong");

  property p_stop_as_wait;
    last && cls == CL_STOP && watchdog_sel_in && !int_req_in |=> wait_mode_out && !stop_mode_out;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) else $error("stop entered with watchdog");

  property p_ctrl_flags;
    last && (cls == CL_NOP || cls == CL_RET || cls == CL_WAIT) && !alu_flag_we_in |=> flags_out == $past(flags_out);
  endproperty
  a_ctrl_flags: assert property (p_ctrl_flags) else $error("control op changed flags");

  property p_ret_addr;
    last && cls == CL_RET && !int_take |=> prog_addr_out == $past(stack_top);
  endproperty
  a_ret_addr: assert property (p_ret_addr) else $error("return address wrong");

endmodule

/* cpu_branch_control_decode_bench.sv */
// Purpose: self-checking bench for the branch, bit and control decoder
// Assumes: program and data memories modelled as arrays read combinationally
// Notes: every scenario except t_reset restarts the core from reset with a fresh program
`include "cbd_defines.svh"

module cpu_branch_control_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cbd_pkg::*;

  // ----------------------------------------
  // signals and memories
  // ----------------------------------------
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] pmem [0:4095];
  logic [7:0] dmem [0:255];
  logic [11:0] prog_addr_out;
  logic [7:0] prog_data_in;
  logic [7:0] data_rdata_in;
  data_req_s data_req_out;
  logic alu_flag_we_in = 1'b0;
  flags_s alu_flags_in = 2'h0;
  flags_s flags_out;
  logic watchdog_sel_in = 1'b0;
  logic int_req_in = 1'b0;
  logic [11:0] int_vec_in = 12'h300;
  logic int_ack_out;
  logic [7:0] opcode_out;
  logic foreign_op_out;
  logic foreign_done_in = 1'b0;
  logic [1:0] foreign_len_in = 2'h1;
  logic wait_mode_out;
  logic stop_mode_out;
  int error_cnt = 0;
  int check_count = 0;

  always #5 clk_sys_in = ~clk_sys_in;
  // memories answer in the same cycle, as the core expects
  assign prog_data_in = pmem[prog_addr_out];
  assign data_rdata_in = dmem[data_req_out.addr];

  cpu_branch_control_decode dut_u (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .prog_data_in(prog_data_in),
    .prog_addr_out(prog_addr_out),
    .data_rdata_in(data_rdata_in),
    .data_req_out(data_req_out),
    .alu_flag_we_in(alu_flag_we_in),
    .alu_flags_in(alu_flags_in),
    .flags_out(flags_out),
    .watchdog_sel_in(watchdog_sel_in),
    .int_req_in(int_req_in),
    .int_vec_in(int_vec_in),
    .int_ack_out(int_ack_out),
    .opcode_out(opcode_out),
    .foreign_op_out(foreign_op_out),
    .foreign_done_in(foreign_done_in),
    .foreign_len_in(foreign_len_in),
    .wait_mode_out(wait_mode_out),
    .stop_mode_out(stop_mode_out)
  );

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic fill();
    for (int i = 0; i < 4096; i++) pmem[i] = `OP_NOP;
  endtask

  // reset, then write flags during cycle 0 of the first instruction
  task automatic start(input flags_s f);
    nrst_in = 1'b0;
    tick(4);
    nrst_in = 1'b1;
    alu_flag_we_in = 1'b1;
    alu_flags_in = f;
    tick(1);
    alu_flag_we_in = 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    nrst_in = 1'b0;
    tick(4);
    check(prog_addr_out, 12'h000, "reset fetch address");
    check(flags_out, 2'h0, "reset flags");
    check(data_req_out, 17'h00000, "reset data request");
    check(opcode_out, 8'h00, "reset opcode");
    check({int_ack_out, foreign_op_out, wait_mode_out, stop_mode_out}, 4'h0, "reset pulses and modes");
  endtask

  // jump to 020 first, then a short branch of magnitude 15 either way
  task automatic t_short(input logic [2:0] kind, input logic dir, input flags_s f);
    logic taken;
    logic [11:0] exp;
    fill();
    pmem[0] = 8'h09;
    pmem[1] = 8'h20;
    pmem[12'h020] = {4'hf, dir, kind};
    case (kind)
      3'h0: taken = !f.z;
      3'h2: taken = !f.c;
      3'h4: taken = f.z;
      default: taken = f.c;
    endcase
    exp = !taken ? 12'h021 : (dir ? 12'h011 : 12'h030);
    start(f);
    tick(3);
    check(prog_addr_out, 12'h020, "jump target after four cycles");
    check(flags_out, f, "jump kept flags");
    tick(1);
    check(prog_addr_out, 12'h021, "short branch second cycle");
    check(opcode_out, {4'hf, dir, kind}, "short branch opcode latched");
    tick(1);
    check(prog_addr_out, exp, "short branch destination");
    check(flags_out, f, "short branch kept flags");
  endtask

  task automatic t_call();
    fill();
    pmem[0] = 8'hf1;
    pmem[1] = 8'h05;
    pmem[12'hf05] = `OP_RET;
    start(2'h3);
    tick(3);
    check(prog_addr_out, 12'hf05, "call target");
    tick(2);
    check(prog_addr_out, 12'h002, "return address");
    check(flags_out, 2'h3, "call and return kept flags");
  endtask

  task automatic t_setclr(input logic [2:0] b, input logic set);
    logic [7:0] exp;
    fill();
    pmem[0] = {b[0], b[1], b[2], set, 4'hb};
    pmem[1] = 8'h40;
    dmem[8'h40] = 8'h5a;
    exp = set ? (8'h5a | (8'h01 << b)) : (8'h5a & ~(8'h01 << b));
    start(2'h2);
    tick(2);
    check(data_req_out.we, 1'b1, "write strobe in cycle 3");
    check(data_req_out.addr, 8'h40, "write address");
    check(data_req_out.wdata, exp, "single bit changed");
    tick(1);
    check(prog_addr_out, 12'h002, "next instruction after four cycles");
    check(data_req_out.we, 1'b0, "strobe one cycle only");
    check(flags_out, 2'h2, "set or clear kept flags");
  endtask

  task automatic t_btest(input logic [2:0] b, input logic set);
    logic [7:0] a;
    logic [7:0] ee;
    logic bitv;
    logic [11:0] exp;
    fill();
    a = 8'h07 + 8'h20 * b;
    // extremes of the displacement: +129 and -126
    ee = set ? 8'h7f : 8'h80;
    pmem[0] = {b[0], b[1], b[2], set, 4'h3};
    pmem[1] = a;
    pmem[2] = ee;
    dmem[a] = 8'ha5;
    bitv = dmem[a][b];
    exp = (bitv == set) ? 12'h002 + {{4{ee[7]}}, ee} : 12'h003;
    start(2'h2);
    tick(4);
    check(prog_addr_out, exp, "bit test destination after five cycles");
    check(flags_out, {1'b1, bitv}, "tested bit in carry, zero kept");
  endtask

  task automatic t_idle(input logic [7:0] op, input logic wd);
    logic as_wait;
    int n;
    fill();
    pmem[0] = op;
    pmem[12'h300] = `OP_INTERRUPT_RETURN;
    watchdog_sel_in = wd;
    as_wait = (op == `OP_WAIT) || wd;
    start(2'h1);
    tick(2);
    check({wait_mode_out, stop_mode_out}, {as_wait, !as_wait}, "low-power mode chosen");
    int_req_in = 1'b1;
    n = 0;
    while (int_ack_out !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check(int_ack_out, 1'b1, "interrupt acknowledged");
    check(prog_addr_out, 12'h300, "vector fetched");
    check({wait_mode_out, stop_mode_out}, 2'h0, "idle left on interrupt");
    // flags overwritten inside the handler must come back on interrupt return
    int_req_in = 1'b0;
    alu_flag_we_in = 1'b1;
    alu_flags_in = 2'h2;
    tick(1);
    alu_flag_we_in = 1'b0;
    check(int_ack_out, 1'b0, "acknowledge one cycle only");
    tick(1);
    check(prog_addr_out, 12'h001, "interrupt return address");
    check(flags_out, 2'h1, "interrupt return restored flags");
    tick(2);
    check(prog_addr_out, 12'h002, "no-operation two cycles");
    watchdog_sel_in = 1'b0;
  endtask

  // an opcode outside these groups is handed out; fetch resumes past its length
  task automatic t_foreign();
    fill();
    pmem[0] = 8'h07;
    start(2'h0);
    tick(1);
    check(foreign_op_out, 1'b1, "handed-out opcode flagged");
    check(opcode_out, 8'h07, "handed-out opcode shown");
    foreign_done_in = 1'b1;
    foreign_len_in = 2'h3;
    tick(1);
    foreign_done_in = 1'b0;
    check(foreign_op_out, 1'b0, "hand-out flag one cycle only");
    check(prog_addr_out, 12'h003, "fetch resumes after handed-out opcode");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    fill();
    t_reset();
    for (int k = 0; k < 8; k += 2) begin
      for (int f = 0; f < 4; f++) begin
        t_short(k[2:0], 1'b0, f[1:0]);
        t_short(k[2:0], 1'b1, f[1:0]);
      end
    end
    t_call();
    t_foreign();
    for (int b = 0; b < 8; b++) begin
      t_setclr(b[2:0], 1'b0);
      t_setclr(b[2:0], 1'b1);
      t_btest(b[2:0], 1'b0);
      t_btest(b[2:0], 1'b1);
    end
    t_idle(`OP_STOP, 1'b0);
    t_idle(`OP_STOP, 1'b1);
    t_idle(`OP_WAIT, 1'b0);
    t_reset();
    conclude();
  end

  // about 650 cycles expected; the margin is generous
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
